// ### ocp_top.sv
// Purpose: two-channel output compare and PWM with a modulo counter
// Assumes: Avalon-MM slave, word addressed, ref_clk 125 MHz
// Notes: ch1 pin falls back to gpio_out while channels are linked
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ocp_regs.svh"
module ocp_top
    import ocp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [`OCP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic gpio_out,
    output logic ch0_pin,
    output logic ch1_pin,
    output logic ovf_irq,
    output logic ch0_irq,
    output logic ch1_irq
);
    ocp_tick_if tk();

    logic tof_reg;
    logic toie_reg;
    logic stop_reg;
    logic [2:0] ps_reg;
    logic [15:0] mod_reg;
    ocp_chcfg_t cfg0_reg;
    ocp_chcfg_t cfg1_reg;
    logic [15:0] val0_reg;
    logic [15:0] val1_reg;
    logic flag0_reg;
    logic flag1_reg;
    logic tof_seen_reg;
    logic f0_seen_reg;
    logic f1_seen_reg;
    logic act1_reg;
    logic pend1_reg;
    logic pin0_reg;
    logic pin1_reg;
    ocp_bus_t bus_reg;
    logic clr_pulse;
    logic wr;
    logic rd;
    logic linked;
    logic [15:0] cmp0_val;
    logic [15:0] cnt_nxt;
    logic cmp0;
    logic cmp1;

    function automatic logic [31:0] chan_status(logic flag, ocp_chcfg_t c);
        chan_status = {24'h000000, flag, c.ie, c.msb, c.msa, c.elsb, c.elsa,
            c.tov, c.max};
    endfunction

    function automatic ocp_chcfg_t chan_cfg(logic [31:0] d);
        chan_cfg = '{ie: d[`OCP_CH_IE], msb: d[`OCP_CH_MSB],
            msa: d[`OCP_CH_MSA], elsb: d[`OCP_CH_ELSB],
            elsa: d[`OCP_CH_ELSA], tov: d[`OCP_CH_TOV],
            max: d[`OCP_CH_MAX]};
    endfunction

    // is the channel in compare/PWM mode (either mode code)
    function automatic logic chan_oc(ocp_chcfg_t c);
        chan_oc = (c.msb ^ c.msa) && (c.elsb || c.elsa);
    endfunction

    // next pin level for one channel on compare and overflow
    function automatic logic pin_next(logic pin, ocp_chcfg_t c, logic cm,
        logic ov);
        logic p;
        p = pin;
        if (cm)
        begin
            if (c.elsb && !c.elsa)
                p = 1'b0;
            else if (c.elsb && c.elsa)
                p = 1'b1;
            else
                p = !p;
        end
        if (c.tov && c.max)
            p = c.elsb && !c.elsa;
        else if (ov && c.tov)
            p = !pin;
        pin_next = p;
    endfunction

    ocp_counter u_cnt (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .halt(stop_reg),
        .clr(clr_pulse),
        .ps_sel(ps_reg),
        .modulo(mod_reg),
        .tk(tk)
    );

    assign wr = avs_write && (bus_reg == OCP_BUS_IDLE);
    assign rd = avs_read && (bus_reg == OCP_BUS_IDLE);
    assign clr_pulse = wr && (avs_address == `OCP_OFF_CTRL)
        && avs_writedata[`OCP_CTRL_RST];
    assign linked = cfg0_reg.msb && !cfg0_reg.msa;
    assign cmp0_val = (linked && act1_reg) ? val1_reg : val0_reg;
    // compare acts as the count arrives, overflow as it leaves the modulo
    assign cnt_nxt = (tk.count == mod_reg) ? `OCP_ZERO16
        : tk.count + `OCP_ONE16;
    assign cmp0 = tk.tick && (cnt_nxt == cmp0_val);
    assign cmp1 = tk.tick && (cnt_nxt == val1_reg) && !linked;

    // one wait state: request taken while waitrequest is high, which drops low the next cycle
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            bus_reg <= OCP_BUS_IDLE;
        else
        begin
            case (bus_reg)
                OCP_BUS_IDLE:
                    if (avs_read || avs_write)
                        bus_reg <= OCP_BUS_ACK;
                OCP_BUS_ACK:
                    bus_reg <= OCP_BUS_IDLE;
                default:
                    bus_reg <= OCP_BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write)
                && bus_reg == OCP_BUS_IDLE);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            avs_readdata <= 32'h00000000;
        else if (rd)
        begin
            case (avs_address)
                `OCP_OFF_CTRL:
                    avs_readdata <= {24'h000000, tof_reg, toie_reg, stop_reg,
                        2'b00, ps_reg};
                `OCP_OFF_CNT: avs_readdata <= {16'h0000, tk.count};
                `OCP_OFF_MOD: avs_readdata <= {16'h0000, mod_reg};
                `OCP_OFF_CH0S:
                    avs_readdata <= chan_status(flag0_reg, cfg0_reg);
                `OCP_OFF_CH0V: avs_readdata <= {16'h0000, val0_reg};
                `OCP_OFF_CH1S:
                    avs_readdata <= chan_status(flag1_reg, cfg1_reg);
                `OCP_OFF_CH1V: avs_readdata <= {16'h0000, val1_reg};
                default: avs_readdata <= 32'h00000000;
            endcase
        end
    end

    // counter control; reset bit is a pulse, never stored
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            toie_reg <= 1'b0;
            stop_reg <= 1'b1;
            ps_reg <= 3'h0;
        end
        else if (wr && avs_address == `OCP_OFF_CTRL)
        begin
            toie_reg <= avs_writedata[`OCP_CTRL_TOIE];
            stop_reg <= avs_writedata[`OCP_CTRL_STOP];
            ps_reg <= (avs_writedata[2:0] > `OCP_PS_MAX) ? `OCP_PS_MAX
                : avs_writedata[2:0];
        end
    end

    // overflow flag: set wins, clear needs a prior read seeing it set
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tof_reg <= 1'b0;
            tof_seen_reg <= 1'b0;
        end
        else if (tk.ovf)
            tof_reg <= 1'b1;
        else if (wr && avs_address == `OCP_OFF_CTRL)
        begin
            if (tof_seen_reg && !avs_writedata[`OCP_CTRL_TOF])
                tof_reg <= 1'b0;
            tof_seen_reg <= 1'b0;
        end
        else if (rd && avs_address == `OCP_OFF_CTRL)
            tof_seen_reg <= tof_reg;
    end

    // modulo is written as one word, so no half-written window exists
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            mod_reg <= `OCP_MOD_RESET;
        else if (wr && avs_address == `OCP_OFF_MOD)
            mod_reg <= avs_writedata[15:0];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg0_reg <= '0;
            cfg1_reg <= '0;
        end
        else if (wr && avs_address == `OCP_OFF_CH0S)
            cfg0_reg <= chan_cfg(avs_writedata);
        else if (wr && avs_address == `OCP_OFF_CH1S && !linked)
            cfg1_reg <= chan_cfg(avs_writedata) & 7'h5F;
    end

    // channel values; a write to the set not in control is queued
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            val0_reg <= `OCP_ZERO16;
            val1_reg <= `OCP_ZERO16;
        end
        else if (wr && avs_address == `OCP_OFF_CH0V)
            val0_reg <= avs_writedata[15:0];
        else if (wr && avs_address == `OCP_OFF_CH1V)
            val1_reg <= avs_writedata[15:0];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            act1_reg <= 1'b0;
            pend1_reg <= 1'b0;
        end
        else if (!linked)
        begin
            act1_reg <= 1'b0;
            pend1_reg <= 1'b0;
        end
        else
        begin
            // pend1_reg remembers which set was written last
            if (wr && avs_address == `OCP_OFF_CH1V)
                pend1_reg <= 1'b1;
            else if (wr && avs_address == `OCP_OFF_CH0V)
                pend1_reg <= 1'b0;
            if (tk.ovf)
                act1_reg <= pend1_reg;
        end
    end

    // channel flags: hardware set wins over a software clear
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag0_reg <= 1'b0;
            f0_seen_reg <= 1'b0;
        end
        else if (cmp0 && chan_oc(cfg0_reg))
            flag0_reg <= 1'b1;
        else if (wr && avs_address == `OCP_OFF_CH0S)
        begin
            if (f0_seen_reg && !avs_writedata[`OCP_CH_FLAG])
                flag0_reg <= 1'b0;
            f0_seen_reg <= 1'b0;
        end
        else if (rd && avs_address == `OCP_OFF_CH0S)
            f0_seen_reg <= flag0_reg;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag1_reg <= 1'b0;
            f1_seen_reg <= 1'b0;
        end
        else if (cmp1 && chan_oc(cfg1_reg))
            flag1_reg <= 1'b1;
        else if (wr && avs_address == `OCP_OFF_CH1S)
        begin
            if (f1_seen_reg && !avs_writedata[`OCP_CH_FLAG])
                flag1_reg <= 1'b0;
            f1_seen_reg <= 1'b0;
        end
        else if (rd && avs_address == `OCP_OFF_CH1S)
            f1_seen_reg <= flag1_reg;
    end

    // registered pin actions
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            pin0_reg <= 1'b0;
        else if (chan_oc(cfg0_reg))
            pin0_reg <= pin_next(pin0_reg, cfg0_reg, cmp0,
                tk.ovf);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            pin1_reg <= 1'b0;
        else if (linked)
            pin1_reg <= gpio_out;
        else if (chan_oc(cfg1_reg))
            pin1_reg <= pin_next(pin1_reg, cfg1_reg, cmp1, tk.ovf);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ovf_irq <= 1'b0;
            ch0_irq <= 1'b0;
            ch1_irq <= 1'b0;
        end
        else
        begin
            ovf_irq <= tof_reg && toie_reg;
            ch0_irq <= flag0_reg && cfg0_reg.ie;
            ch1_irq <= flag1_reg && cfg1_reg.ie && !linked;
        end
    end

    assign ch0_pin = pin0_reg;
    assign ch1_pin = pin1_reg;
endmodule

// ### ocp_regs.svh
// Purpose: register map, field positions, reset values and counts
// Assumes: 32-bit Avalon-MM word addressing, offsets in words
// Notes: constants only
`ifndef OCP_REGS_SVH
`define OCP_REGS_SVH
`define OCP_ADDR_W 4
`define OCP_OFF_CTRL 4'h0
`define OCP_OFF_CNT 4'h1
`define OCP_OFF_MOD 4'h2
`define OCP_OFF_CH0S 4'h3
`define OCP_OFF_CH0V 4'h4
`define OCP_OFF_CH1S 4'h5
`define OCP_OFF_CH1V 4'h6
`define OCP_CTRL_TOF 7
`define OCP_CTRL_TOIE 6
`define OCP_CTRL_STOP 5
`define OCP_CTRL_RST 4
`define OCP_CH_FLAG 7
`define OCP_CH_IE 6
`define OCP_CH_MSB 5
`define OCP_CH_MSA 4
`define OCP_CH_ELSB 3
`define OCP_CH_ELSA 2
`define OCP_CH_TOV 1
`define OCP_CH_MAX 0
`define OCP_MOD_RESET 16'hFFFF
`define OCP_PS_MAX 3'h6
`define OCP_ZERO16 16'h0000
`define OCP_ONE16 16'h0001
`endif

// ### ocp_pkg.sv
// Purpose: shared types of the output compare block
// Assumes: nothing
// Notes: types only
package ocp_pkg;
    typedef enum logic [1:0] {OCP_BUS_IDLE, OCP_BUS_ACK} ocp_bus_t;
    typedef struct packed {
        logic ie;
        logic msb;
        logic msa;
        logic elsb;
        logic elsa;
        logic tov;
        logic max;
    } ocp_chcfg_t;
endpackage

// ### ocp_tick_if.sv
// Purpose: carries the counter tick and events to the channel logic
// Assumes: single clock
// Notes: one modport per side
`timescale 1ns/1ps
interface ocp_tick_if;
    logic tick;
    logic [15:0] count;
    logic ovf;
    modport src (output tick, output count, output ovf);
    modport dst (input tick, input count, input ovf);
endinterface

// ### ocp_counter.sv
// Purpose: prescaler and 16-bit modulo counter
// Assumes: controls come from registers in ref_clk domain
// Notes: ovf marks the tick on which the count equals the modulo
`timescale 1ns/1ps
`include "ocp_regs.svh"
module ocp_counter
    import ocp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic halt,
    input wire logic clr,
    input wire logic [2:0] ps_sel,
    input wire logic [15:0] modulo,
    ocp_tick_if.src tk
);
    logic [5:0] pre_reg;
    logic [15:0] cnt_reg;
    logic tick;
    logic [5:0] pre_mask;

    always_comb
    begin
        pre_mask = 6'(( 7'h01 << ps_sel) - 7'h01);
        tick = !halt && ((pre_reg & pre_mask) == pre_mask);
    end

    // prescaler advance, cleared by the counter reset bit
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            pre_reg <= 6'h00;
        else if (clr)
            pre_reg <= 6'h00;
        else if (!halt)
            pre_reg <= pre_reg + 6'h01;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_reg <= `OCP_ZERO16;
        else if (clr)
            cnt_reg <= `OCP_ZERO16;
        else if (tick)
        begin
            if (cnt_reg == modulo)
                cnt_reg <= `OCP_ZERO16;
            else
                cnt_reg <= cnt_reg + `OCP_ONE16;
        end
    end

    assign tk.tick = tick;
    assign tk.count = cnt_reg;
    assign tk.ovf = tick && (cnt_reg == modulo);
endmodule

// ### ocp_chk.sv
// Purpose: concurrent checks on the output compare block ports
// Assumes: shadow registers follow accepted bus writes
// Notes: bound to ocp_top after the module
`timescale 1ns/1ps
`include "ocp_regs.svh"
module ocp_chk
    import ocp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [`OCP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic gpio_out,
    input wire logic ch0_pin,
    input wire logic ch1_pin,
    input wire logic ovf_irq,
    input wire logic ch0_irq
);
    logic [6:0] cfg0_reg;
    logic toie_reg;
    logic [15:0] mod_reg;
    logic acc_w;
    assign acc_w = avs_write && !avs_waitrequest;
    // shadow lags the block by one cycle, so the duty checks skip write cycles and the link and irq checks also test the cycle before
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cfg0_reg <= 7'h00;
            toie_reg <= 1'h0;
            mod_reg <= `OCP_MOD_RESET;
        end
        else if (acc_w)
        begin
            if (avs_address == `OCP_OFF_CH0S)
                cfg0_reg <= avs_writedata[6:0];
            if (avs_address == `OCP_OFF_CTRL)
                toie_reg <= avs_writedata[`OCP_CTRL_TOIE];
            if (avs_address == `OCP_OFF_MOD)
                mod_reg <= avs_writedata[15:0];
        end
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    a_wait_one_cycle:
        assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_bounded:
        assert property ((avs_read || avs_write) && avs_waitrequest
            |-> ##[1:2] !avs_waitrequest)
        else $error("bus request not answered in time");
    a_rst_bit_zero:
        assert property (avs_read && !avs_waitrequest
            && avs_address == `OCP_OFF_CTRL |-> !avs_readdata[4])
        else $error("counter reset bit read back as one");
    a_count_in_mod:
        assert property (avs_read && !avs_waitrequest
            && avs_address == `OCP_OFF_CNT |-> avs_readdata[15:0] <= mod_reg)
        else $error("count read above modulo");
    a_link_gpio_follow:
        assert property (cfg0_reg[5] && !cfg0_reg[4] && $past(cfg0_reg[5])
            |-> ch1_pin == $past(gpio_out))
        else $error("ch1 pin does not follow gpio while linked");
    a_zero_duty_low:
        assert property (cfg0_reg == 7'h18 && !avs_write && !ch0_pin
            |=> !ch0_pin)
        else $error("ch0 pin rose at zero duty");
    a_full_duty_high:
        assert property (cfg0_reg == 7'h1B && !avs_write && ch0_pin
            |=> ch0_pin)
        else $error("ch0 pin dropped at full duty");
    a_ovf_irq_off:
        assert property (!toie_reg && !$past(toie_reg) |-> !ovf_irq)
        else $error("overflow irq while disabled");
    a_ch0_irq_off:
        assert property (!cfg0_reg[6] && !$past(cfg0_reg[6]) |-> !ch0_irq)
        else $error("ch0 irq while disabled");
endmodule
bind ocp_top ocp_chk i_ocp_chk (.ref_clk, .reset_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .gpio_out, .ch0_pin, .ch1_pin, .ovf_irq, .ch0_irq);

// ### ocp_load.sv
// Purpose: load on a channel pin that measures each pwm period
// Assumes: pin is registered in the ref_clk domain
// Notes: outputs describe the last complete period, rise to rise
`timescale 1ns/1ps
module ocp_load
    import ocp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic pin,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    logic prev_reg;
    logic [15:0] cnt_reg;
    logic [15:0] hi_reg;
    always_ff @(posedge ref_clk)
    begin
        prev_reg <= pin;
        if (pin && !prev_reg)
        begin
            per_len <= cnt_reg;
            hi_len <= hi_reg;
            cnt_reg <= 16'h0001;
            hi_reg <= 16'h0001;
        end
        else
        begin
            cnt_reg <= cnt_reg + 16'h0001;
            hi_reg <= hi_reg + {15'h0000, pin};
        end
    end
endmodule

// ### output_compare_pwm_channels_test.sv
// Purpose: register driven tests of compare and pwm behaviour
// Assumes: one wait state per access, modulo kept at 7
// Notes: pwm shape is measured by the load model on ch0
`timescale 1ns/1ps
`include "ocp_regs.svh"
module output_compare_pwm_channels_test;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [`OCP_ADDR_W-1:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic gpio_out = 1'h0;
    logic ch0_pin;
    logic ch1_pin;
    logic ovf_irq;
    logic ch0_irq;
    logic ch1_irq;
    logic [15:0] hi_len;
    logic [15:0] per_len;
    logic [31:0] q;
    int error_cnt = 0;
    int checks = 0;
    always #4 ref_clk = ~ref_clk;
    ocp_top i_ocp_top (.ref_clk, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .gpio_out, .ch0_pin, .ch1_pin, .ovf_irq, .ch0_irq, .ch1_irq);
    ocp_load i_ocp_load (.ref_clk, .pin(ch0_pin), .hi_len, .per_len);
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic bus(input logic [3:0] a, input logic w,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'h0)
        begin
            n++;
            @(posedge ref_clk);
        end
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        chk("wait states", 32'(n), 32'h1);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(a, 1'h1, d);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] e, input string nm);
        bus(a, 1'h0, 32'h0);
        chk(nm, q & m, e);
    endtask
    task automatic shape(input logic [15:0] hi, input logic [15:0] per);
        repeat (32) @(posedge ref_clk);
        chk("pulse high", {16'h0, hi_len}, {16'h0, hi});
        chk("period", {16'h0, per_len}, {16'h0, per});
    endtask
    task automatic level(input logic lv);
        int n;
        n = 0;
        repeat (24) @(posedge ref_clk);
        repeat (24)
        begin
            @(posedge ref_clk);
            n += (ch0_pin === lv);
        end
        chk("steady level", 32'(n), 32'h18);
    endtask
    initial
    begin
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'h1;
        rdc(`OCP_OFF_CTRL, 32'hFF, 32'h20, "ctrl reset");
        rdc(`OCP_OFF_MOD, 32'hFFFF, 32'hFFFF, "modulo reset");
        wr(`OCP_OFF_CTRL, 32'h0);
        repeat (10) @(posedge ref_clk);
        wr(`OCP_OFF_CTRL, 32'h20);
        wr(`OCP_OFF_CTRL, 32'h30);
        rdc(`OCP_OFF_CNT, 32'hFFFF, 32'h0, "count cleared");
        rdc(`OCP_OFF_CTRL, 32'h10, 32'h0, "reset bit");
        wr(`OCP_OFF_MOD, 32'h7);
        wr(`OCP_OFF_CH0V, 32'h3);
        wr(`OCP_OFF_CH0S, 32'h1A);
        wr(`OCP_OFF_CTRL, 32'h0);
        shape(16'h3, 16'h8);
        rdc(`OCP_OFF_CH0S, 32'h80, 32'h80, "compare flag");
        rdc(`OCP_OFF_CTRL, 32'h80, 32'h80, "ovf flag");
        @(posedge ch0_pin);
        wr(`OCP_OFF_CH0V, 32'h5);
        shape(16'h5, 16'h8);
        @(negedge ch0_pin);
        wr(`OCP_OFF_CH0V, 32'h3);
        shape(16'h3, 16'h8);
        wr(`OCP_OFF_CH0S, 32'h1E);
        shape(16'h5, 16'h8);
        wr(`OCP_OFF_CH0S, 32'h18);
        level(1'h0);
        wr(`OCP_OFF_CH0S, 32'h1B);
        level(1'h1);
        wr(`OCP_OFF_CH0V, 32'h3);
        wr(`OCP_OFF_CH0S, 32'h2A);
        shape(16'h3, 16'h8);
        wr(`OCP_OFF_CH1V, 32'h6);
        shape(16'h6, 16'h8);
        wr(`OCP_OFF_CH0V, 32'h2);
        shape(16'h2, 16'h8);
        wr(`OCP_OFF_CH1S, 32'h5B);
        rdc(`OCP_OFF_CH1S, 32'h7F, 32'h0, "ch1 status");
        gpio_out <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk("ch1 pin", {31'h0, ch1_pin}, 32'h1);
        wr(`OCP_OFF_CTRL, 32'h40);
        wr(`OCP_OFF_CH0S, 32'h6A);
        repeat (24) @(posedge ref_clk);
        chk("irqs", {29'h0, ch1_irq, ovf_irq, ch0_irq}, 32'h3);
        rdc(4'h7, 32'hFFFFFFFF, 32'h0, "unmapped read");
        give_verdict;
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        give_verdict;
    end
endmodule
